// [inc/brake_pkg.sv]
// Constants shared by the dual brake monitor.
// Assumes a 50 MHz control tick drives all logic.
package brake_pkg;
    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TIME_OFS = 8'h04;
    localparam logic [7:0] KEY_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [7:0] ISTAT_OFS = 8'h10;
    localparam logic [7:0] IMASK_OFS = 8'h14;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RESET_CMD_BIT = 1;
    localparam logic ENABLE_RST = 1'h0;
    localparam int TIME_W = 16;
    localparam logic [15:0] CHECK_TIME_RST = 16'h0064;
    localparam int KEY_W = 8;
    // Clear key is decimal 111
    localparam logic [7:0] CLEAR_KEY_VALUE = 8'h6F;
    localparam logic [7:0] KEY_RST = 8'h00;
    localparam int IRQ_W = 3;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_TRAVEL = 1;
    localparam int IRQ_SINGLE = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
endpackage

// [inc/brake_if.sv]
// Carriers between the monitor top and its helpers.
// Assumes brake_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// One feedback check channel
// ----------------------------------------
interface brake_chk_if import brake_pkg::*; ();
    logic active; // Channel supervises
    logic feedback; // 1 = brake reports released
    logic command; // Release command
    logic [TIME_W-1:0] check_time; // Limit in ticks
    logic mismatch; // Feedback disagrees
    logic expired; // Disagreement outlived limit
    modport ctrl(output active, feedback, command, check_time, input mismatch, expired);
    modport chan(input active, feedback, command, check_time, output mismatch, expired);
endinterface
// ----------------------------------------
// Brake fault latch
// ----------------------------------------
interface alarm_if ();
    logic [1:0] set_req; // Expiry per brake
    logic hold; // Car travelling
    logic clear; // Keyed clear
    logic load; // Restore retained state
    logic load_val; // Retained alarm value
    logic alarm; // Latched alarm
    logic [1:0] pending; // Recorded brake faults
    modport ctrl(output set_req, hold, clear, load, load_val, input alarm, pending);
    modport latch(input set_req, hold, clear, load, load_val, output alarm, pending);
endinterface
`default_nettype wire

// [core/brake_check_channel.sv]
// One brake feedback checker with its check timer.
// Assumes feedback and command are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module brake_check_channel import brake_pkg::*; (
    input wire logic mclk,
    input wire logic reset,
    brake_chk_if.chan bus
);
    // ----------------------------------------
    // Check timer
    // ----------------------------------------
    logic [TIME_W-1:0] count; // Ticks in disagreement

    assign bus.mismatch = bus.active & (bus.feedback ^ bus.command);
    // Fires only once count reached the limit, so strictly longer
    assign bus.expired = bus.mismatch & (count == bus.check_time);

    // Held at zero on agreement; saturates at the limit
    always_ff @(posedge mclk) begin
        if (reset || !bus.mismatch) begin
            count <= '0;
        end else if (count < bus.check_time) begin
            count <= count + 16'h0001;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_timer_zero;
        @(posedge mclk) disable iff (reset)
        !bus.mismatch |=> (count == '0);
    endproperty
    a_timer_zero: assert property (p_timer_zero) else $error("timer not cleared");

    property p_timer_step;
        @(posedge mclk) disable iff (reset)
        (bus.mismatch && count < bus.check_time) |=> (!bus.mismatch || count == $past(count) + 16'h0001);
    endproperty
    a_timer_step: assert property (p_timer_step) else $error("timer did not count");
endmodule
`default_nettype wire

// [core/brake_alarm_latch.sv]
// Latched brake fault with travel hold-back and keyed clear.
// Assumes clear is only pulsed after a valid key.
`timescale 1ns/1ps
`default_nettype none
module brake_alarm_latch (
    input wire logic mclk,
    input wire logic reset,
    alarm_if.latch bus
);
    // ----------------------------------------
    // Fault record and alarm
    // ----------------------------------------
    logic issue; // Recorded fault may show

    // Faults in travel wait until the car stops
    assign issue = (|bus.pending) & ~bus.hold;

    // New expiry wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus.pending <= 2'h0;
        end else begin
            bus.pending <= (bus.clear ? 2'h0 : bus.pending) | bus.set_req;
        end
    end

    // No path clears the alarm except the keyed clear
    // The clear empties the record as well, so an old record cannot hold the
    // alarm up; an expiry in the clear cycle stays recorded and re-raises it
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus.alarm <= 1'h0;
        end else if (bus.load) begin
            bus.alarm <= bus.load_val;
        end else if (bus.clear) begin
            bus.alarm <= 1'h0;
        end else if (issue) begin
            bus.alarm <= 1'h1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_travel_hold;
        @(posedge mclk) disable iff (reset || bus.load)
        (bus.hold && !bus.alarm) |=> !bus.alarm;
    endproperty
    a_travel_hold: assert property (p_travel_hold) else $error("alarm during travel");
endmodule
`default_nettype wire

// [core/dual_brake_feedback_monitor.sv]
// Dual brake feedback monitor with AXI4-Lite registers.
// Assumes pins are synchronous to mclk, feedback 1 = released.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module dual_brake_feedback_monitor import brake_pkg::*; (
    input wire logic mclk,
    input wire logic reset,
    input wire logic first_brake_feedback,
    input wire logic second_brake_feedback,
    input wire logic single_brake_feedback,
    input wire logic brake_release_command,
    input wire logic car_travelling,
    input wire logic rescue_brake_override,
    input wire logic nv_fault_restore,
    output logic brake_fault_alarm,
    output logic single_brake_fault,
    output logic output_block,
    output logic nv_fault_store,
    output logic irq,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic enable; // Dual monitor enable
    logic [TIME_W-1:0] check_time; // Limit in ticks
    logic [KEY_W-1:0] clear_key; // Clear key register
    logic [IRQ_W-1:0] irq_status; // Sticky events
    logic [IRQ_W-1:0] irq_mask; // Event gates
    logic [IRQ_W-1:0] irq_event; // Events this cycle
    logic aw_got; // Write address held
    logic w_got; // Write data held
    logic [AXI_ADDR_W-1:0] aw_addr; // Held write address
    logic [AXI_DATA_W-1:0] w_data; // Held write data
    logic [3:0] w_strb; // Held byte enables
    logic wr_fire; // Write executes
    logic wr_hit; // Write address mapped
    logic reset_cmd; // Alarm reset command
    logic clear_now; // Keyed clear accepted
    logic active; // Dual supervision running
    logic hold; // Car in travel
    logic restore_pending; // First cycle after reset
    logic single_fault; // Single feedback fault
    logic alarm_q; // Alarm one cycle ago
    logic [AXI_DATA_W-1:0] next_rdata; // Read mux
    logic rd_hit; // Read address mapped

    brake_chk_if ch1 ();
    brake_chk_if ch2 ();
    brake_chk_if chs ();
    alarm_if al ();

    // ----------------------------------------
    // Supervision wiring
    // ----------------------------------------
    // Rescue override suspends both dual channels, so a brake opened
    // externally at standstill never reaches their timers
    assign active = enable & ~rescue_brake_override;
    assign hold = car_travelling & brake_release_command;

    assign ch1.active = active;
    assign ch1.feedback = first_brake_feedback;
    assign ch1.command = brake_release_command;
    assign ch1.check_time = check_time;
    assign ch2.active = active;
    assign ch2.feedback = second_brake_feedback;
    assign ch2.command = brake_release_command;
    assign ch2.check_time = check_time;
    // Single feedback check runs only while dual monitor is off
    assign chs.active = ~enable;
    assign chs.feedback = single_brake_feedback;
    assign chs.command = brake_release_command;
    assign chs.check_time = check_time;

    // Either direction of disagreement trips: not released at
    // start, still released at stop, opened at standstill
    assign al.set_req = {ch2.expired, ch1.expired};
    assign al.hold = hold;
    assign al.clear = clear_now;
    assign al.load = restore_pending;
    assign al.load_val = nv_fault_restore;

    brake_check_channel u_ch1 (.mclk(mclk), .reset(reset), .bus(ch1));
    brake_check_channel u_ch2 (.mclk(mclk), .reset(reset), .bus(ch2));
    brake_check_channel u_chs (.mclk(mclk), .reset(reset), .bus(chs));
    brake_alarm_latch u_latch (.mclk(mclk), .reset(reset), .bus(al));

    // Retained alarm is reloaded once reset has released
    always_ff @(posedge mclk) begin
        if (reset) begin
            restore_pending <= 1'h1;
        end else begin
            restore_pending <= 1'h0;
        end
    end

    // ----------------------------------------
    // Single feedback fault
    // ----------------------------------------
    // Ordinary alarm: a plain reset command clears it
    always_ff @(posedge mclk) begin
        if (reset) begin
            single_fault <= 1'h0;
        end else if (chs.expired) begin
            single_fault <= 1'h1;
        end else if (reset_cmd) begin
            single_fault <= 1'h0;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
    assign wr_hit = (aw_addr == CTRL_OFS) || (aw_addr == TIME_OFS) || (aw_addr == KEY_OFS)
        || (aw_addr == STAT_OFS) || (aw_addr == ISTAT_OFS) || (aw_addr == IMASK_OFS);
    assign reset_cmd = wr_fire & (aw_addr == CTRL_OFS) & w_strb[0] & w_data[CTRL_RESET_CMD_BIT];
    // Alarm only clears with the key armed first
    assign clear_now = reset_cmd & (clear_key == CLEAR_KEY_VALUE);

    // Address capture; one write in flight at a time
    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_got <= 1'h0;
            aw_addr <= '0;
            s_axi_awready <= 1'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'h1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got <= 1'h0;
            end
            s_axi_awready <= ~aw_got & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid & ~wr_fire;
        end
    end

    // Data capture, independent of the address
    always_ff @(posedge mclk) begin
        if (reset) begin
            w_got <= 1'h0;
            w_data <= '0;
            w_strb <= 4'h0;
            s_axi_wready <= 1'h0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'h1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got <= 1'h0;
            end
            s_axi_wready <= ~w_got & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid & ~wr_fire;
        end
    end

    // Response once both halves are in
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            enable <= ENABLE_RST;
            check_time <= CHECK_TIME_RST;
            irq_mask <= IRQ_RST;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == CTRL_OFS) begin
                enable <= w_data[CTRL_ENABLE_BIT];
            end
            if (aw_addr == TIME_OFS) begin
                check_time[7:0] <= w_data[7:0];
            end
            if (aw_addr == IMASK_OFS) begin
                irq_mask <= w_data[IRQ_W-1:0];
            end
        end
        if (!reset && wr_fire && w_strb[1] && aw_addr == TIME_OFS) begin
            check_time[15:8] <= w_data[15:8];
        end
    end

    // Key returns to zero on its own once used
    always_ff @(posedge mclk) begin
        if (reset) begin
            clear_key <= KEY_RST;
        end else if (clear_now) begin
            clear_key <= KEY_RST;
        end else if (wr_fire && w_strb[0] && aw_addr == KEY_OFS) begin
            clear_key <= w_data[KEY_W-1:0];
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    assign irq_event[IRQ_ALARM] = al.alarm & ~alarm_q;
    assign irq_event[IRQ_TRAVEL] = (|al.set_req) & hold;
    assign irq_event[IRQ_SINGLE] = chs.expired & ~single_fault;

    // Write one clears; a new event wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_status <= IRQ_RST;
        end else if (wr_fire && w_strb[0] && aw_addr == ISTAT_OFS) begin
            irq_status <= (irq_status & ~w_data[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    always_comb begin
        next_rdata = '0;
        rd_hit = 1'h1;
        unique case (s_axi_araddr)
            CTRL_OFS: next_rdata[CTRL_ENABLE_BIT] = enable;
            TIME_OFS: next_rdata[TIME_W-1:0] = check_time;
            KEY_OFS: next_rdata[KEY_W-1:0] = clear_key;
            STAT_OFS: next_rdata[6:0] = {ch2.mismatch, ch1.mismatch, active, single_fault,
                al.pending, al.alarm};
            ISTAT_OFS: next_rdata[IRQ_W-1:0] = irq_status;
            IMASK_OFS: next_rdata[IRQ_W-1:0] = irq_mask;
            default: rd_hit = 1'h0; // Unmapped reads zero
        endcase
    end

    // One read in flight; answer the cycle after the address
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~(s_axi_arvalid & s_axi_arready) & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'h1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'h0;
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    // Any latched fault stops the drive
    always_ff @(posedge mclk) begin
        if (reset) begin
            alarm_q <= 1'h0;
            brake_fault_alarm <= 1'h0;
            single_brake_fault <= 1'h0;
            output_block <= 1'h0;
            nv_fault_store <= 1'h0;
            irq <= 1'h0;
        end else begin
            alarm_q <= al.alarm;
            brake_fault_alarm <= al.alarm;
            single_brake_fault <= single_fault;
            output_block <= al.alarm | single_fault;
            nv_fault_store <= al.alarm;
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_reset_off;
        @(posedge mclk) reset |=> !enable;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("enable set after reset");

    property p_single_only;
        @(posedge mclk) disable iff (reset)
        enable |-> (!chs.active && !chs.expired);
    endproperty
    a_single_only: assert property (p_single_only) else $error("single check while enabled");

    property p_rescue;
        @(posedge mclk) disable iff (reset)
        rescue_brake_override |-> (!ch1.expired && !ch2.expired);
    endproperty
    a_rescue: assert property (p_rescue) else $error("check ran under rescue");

    property p_issue;
        @(posedge mclk) disable iff (reset || restore_pending)
        (ch1.expired && !hold && !clear_now) |-> ##2 al.alarm;
    endproperty
    a_issue: assert property (p_issue) else $error("expiry gave no alarm");

    property p_latched;
        @(posedge mclk) disable iff (reset || restore_pending)
        (al.alarm && !clear_now) |=> al.alarm;
    endproperty
    a_latched: assert property (p_latched) else $error("alarm dropped without key");

    property p_block;
        @(posedge mclk) disable iff (reset)
        al.alarm |=> output_block;
    endproperty
    a_block: assert property (p_block) else $error("output not blocked");

    property p_key_clear;
        @(posedge mclk) disable iff (reset)
        clear_now |=> (clear_key == KEY_RST) && !al.alarm ##1 !brake_fault_alarm;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("keyed clear failed");

    c_alarm: cover property (@(posedge mclk) disable iff (reset) $rose(al.alarm));
    c_travel: cover property (@(posedge mclk) disable iff (reset) irq_event[IRQ_TRAVEL]);
    c_clear: cover property (@(posedge mclk) disable iff (reset) clear_now && al.alarm);
endmodule
`default_nettype wire

// [dv/brake_switch_model.sv]
// Model of the two brake limit switches and the single switch.
// Assumes the bench drives the release command and fault controls.
`timescale 1ns/1ps
`default_nettype none
module brake_switch_model (
    input wire logic mclk,
    input wire logic command,
    input wire logic [1:0] stuck_en,
    input wire logic [1:0] stuck_val,
    output logic first_fb,
    output logic second_fb,
    output logic single_fb
);
    // ----------------------------------------
    // Switch contacts
    // ----------------------------------------
    // Contacts follow the coil one tick late, like a real armature
    // A stuck contact shows the forced level; the bench sets it
    // Single switch shares the first brake's fault controls
    always @(posedge mclk) begin
        first_fb <= stuck_en[0] ? stuck_val[0] : command;
        second_fb <= stuck_en[1] ? stuck_val[1] : command;
        single_fb <= stuck_en[0] ? stuck_val[0] : command;
    end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the dual brake monitor.
// Assumes brake_pkg, the design and the switch model are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_top import brake_pkg::*;;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic mclk = 1'b0, reset = 1'b1, cmd = 1'b0, trav = 1'b0, resc = 1'b0, nvr = 1'b0;
    logic [1:0] st_en = 2'h0, st_val = 2'h0, bresp, rresp;
    logic fb1, fb2, fbs, alarm, sfault, oblk, nvs, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [65:0] notes[$]; // Expected read: resp, mask, data
    logic [65:0] note;
    logic [15:0] ct; // Check time in ticks, random
    int failures = 0, comparisons = 0;
    initial begin
        forever #10 mclk = ~mclk;
    end
    brake_switch_model partner (.mclk(mclk), .command(cmd), .stuck_en(st_en), .stuck_val(st_val),
        .first_fb(fb1), .second_fb(fb2), .single_fb(fbs));
    // Byte lanes stay all on; the lane logic is not under test here
    dual_brake_feedback_monitor dut (.mclk(mclk), .reset(reset), .first_brake_feedback(fb1),
        .second_brake_feedback(fb2), .single_brake_feedback(fbs), .brake_release_command(cmd),
        .car_travelling(trav), .rescue_brake_override(resc), .nv_fault_restore(nvr),
        .brake_fault_alarm(alarm), .single_brake_fault(sfault), .output_block(oblk),
        .nv_fault_store(nvs), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [65:0] seen, input logic [65:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Alarm pin and drive block move together for dual faults
    task pins(input logic e);
        chk(66'({oblk, alarm, sfault}), 66'({e, e, 1'b0}));
    endtask
    // Write: offer both channels, hold bready until the answer
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 100) failures++;
        if (n == 100) close_out;
        chk(66'(bresp), 66'(RESP_OKAY));
        @(posedge mclk);
    endtask
    // Read: the expectation is noted, the monitor compares it
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
        int n;
        notes.push_back({r, m, e});
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 100) failures++;
        if (n == 100) close_out;
        @(posedge mclk);
    endtask
    // Keyed clear: key first, then the reset command, enable kept
    task clr;
        wr(KEY_OFS, 32'h6F);
        wr(CTRL_OFS, 32'h3);
        tick(3);
        pins(1'b0);
        rd(KEY_OFS, 32'hFF, 32'h0, RESP_OKAY);
    endtask
    // Result watcher: oldest note against each read answer
    always @(posedge mclk) begin
        if (rvalid && rready) begin
            note = notes.pop_front();
            chk({rresp, note[63:32], rdata & note[63:32]}, note);
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h4477));
        tick(12);
        reset <= 1'b0;
        tick(2);
        rd(CTRL_OFS, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
        rd(TIME_OFS, 32'hFFFFFFFF, {16'h0, CHECK_TIME_RST}, RESP_OKAY);
        rd(8'h18, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        $display("test reset_values done");
        // Disabled monitor keeps the alarm off; the single check flags a brake that never opens
        cmd <= 1'b1;
        st_en <= 2'h1;
        st_val <= 2'h0;
        tick(120);
        chk(66'({oblk, alarm, sfault}), 66'h5);
        cmd <= 1'b0;
        st_en <= 2'h0;
        ct = 16'(3 + $urandom % 6);
        wr(TIME_OFS, {16'h0, ct});
        wr(IMASK_OFS, 32'h1);
        // Reset command drops the single fault as the monitor comes on
        wr(CTRL_OFS, 32'h3);
        $display("test disabled done");
        // Opening exactly check time ticks is still tolerated
        st_en <= 2'h2;
        st_val <= 2'h2;
        tick(ct);
        st_en <= 2'h0;
        tick(ct + 8);
        pins(1'b0);
        // Brake 2 never opens at travel start
        cmd <= 1'b1;
        st_en <= 2'h2;
        st_val <= 2'h0;
        tick(ct + 8);
        pins(1'b1);
        chk(66'(irq), 66'h1);
        rd(STAT_OFS, 32'h5, 32'h5, RESP_OKAY);
        wr(IMASK_OFS, 32'h0);
        tick(2);
        chk(66'(irq), 66'h0);
        wr(ISTAT_OFS, 32'h1);
        wr(IMASK_OFS, 32'h1);
        tick(2);
        chk(66'(irq), 66'h0);
        cmd <= 1'b0;
        st_en <= 2'h0;
        wr(CTRL_OFS, 32'h3);
        tick(3);
        pins(1'b1);
        clr;
        $display("test start_fault done");
        // Brake 1 held closed for a while during travel shows at the stop
        {trav, cmd} <= 2'h3;
        tick(3);
        st_en <= 2'h1;
        tick(ct + 4);
        st_en <= 2'h0;
        tick(5);
        pins(1'b0);
        rd(STAT_OFS, 32'h2, 32'h2, RESP_OKAY);
        rd(ISTAT_OFS, 32'h2, 32'h2, RESP_OKAY);
        {trav, cmd} <= 2'h0;
        tick(ct + 6);
        pins(1'b1);
        clr;
        // Brake 2 stays open after the stop
        cmd <= 1'b1;
        tick(3);
        {st_en, st_val, cmd} <= 5'h14;
        tick(ct + 8);
        pins(1'b1);
        st_en <= 2'h0;
        clr;
        $display("test travel done");
        // Brake opened at standstill, with and without rescue
        {resc, st_en, st_val} <= 5'h15;
        tick(ct + 8);
        pins(1'b0);
        resc <= 1'b0;
        tick(ct + 8);
        pins(1'b1);
        st_en <= 2'h0;
        clr;
        $display("test standstill done");
        // Retained alarm comes back after a power cycle
        {reset, nvr} <= 2'h3;
        tick(2);
        reset <= 1'b0;
        tick(4);
        pins(1'b1);
        chk(66'(nvs), 66'h1);
        $display("test retention done");
        close_out;
    end
endmodule
`default_nettype wire
